// ---- hw/rts_sequencer.sv ----
// reset timeout sequencer with power status flags and axi4-lite registers
// How it works
// - brown-out detection works only with fuse set
// - supply below threshold past minimum duration resets
// - reset held until supply recovers, then delay
// - delay fuse set means no start-up delay
// - dip during delay restarts it from zero
// - delay follows power-on pulse, settle follows delay
// - timers ignore pin; late pin release runs immediately
// - crystal modes add 1024 oscillator periods, wake too
// - power status: brown-out bit 0, power-on bit 1
// - brown-out flag cleared by brown-out unless a power-on pulse comes in the same cycle, software sets
// - brown-out flag meaningless while detection disabled
// - power-on flag cleared by power-on only
// - cause readable from the four flags
// - watchdog time-out clears expiry flag unless a power-on or brown-out comes in the same cycle
//
// The AXI4-Lite slave port was chosen for this implementation.
module rts_sequencer #(
  parameter int STARTUP_CYCLES = rts_pkg::STARTUP_DELAY_CYCLES,
  parameter int BROWNOUT_CYCLES = rts_pkg::BROWNOUT_MIN_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // supply and reset sources
  input wire logic power_on_pulse,
  input wire logic supply_below_threshold,
  input wire logic external_reset_pin_n,
  input wire logic brownout_enable_fuse,
  input wire logic startup_delay_enable_n,
  input wire logic [2:0] osc_mode,
  input wire logic osc_tick,
  input wire logic watchdog_timeout,
  input wire logic sleep_enter,
  input wire logic sleep_active,
  input wire logic wake_request,
  output logic core_reset,
  output logic wake_hold,
  output logic irq,
  // axi4-lite slave
  input wire logic [rts_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [rts_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // byte address to register select
  function automatic rts_pkg::rts_sel_type decode(input logic [rts_pkg::ADDR_W-1:0] addr);
    logic [9:0] idx;
    idx = addr[rts_pkg::ADDR_W-1:2];
    if (addr[1:0] != 2'h0) return rts_pkg::RTS_SEL_NONE;
    if (idx == rts_pkg::IDX_POWER_STATUS) return rts_pkg::RTS_SEL_PS;
    if (idx == rts_pkg::IDX_CORE_FLAGS) return rts_pkg::RTS_SEL_CF;
    if (idx == rts_pkg::IDX_SEQ_STATE) return rts_pkg::RTS_SEL_SEQ;
    if (idx == rts_pkg::IDX_IRQ_STATUS) return rts_pkg::RTS_SEL_IST;
    if (idx == rts_pkg::IDX_IRQ_MASK) return rts_pkg::RTS_SEL_IMSK;
    return rts_pkg::RTS_SEL_NONE;
  endfunction

  // crystal style oscillators need the settle count
  function automatic logic is_crystal(input logic [2:0] mode);
    return (mode == rts_pkg::RTS_CRYSTAL_MODE) || (mode == rts_pkg::RTS_HIGH_SPEED_CRYSTAL_MODE) ||
           (mode == rts_pkg::RTS_LOW_POWER_CRYSTAL_MODE);
  endfunction

  localparam logic [rts_pkg::DELAY_CNT_W-1:0] DELAY_LAST = rts_pkg::DELAY_CNT_W'(STARTUP_CYCLES - 1);
  localparam logic [rts_pkg::OSC_CNT_W-1:0] SETTLE_LAST = rts_pkg::OSC_CNT_W'(rts_pkg::SETTLE_OSC_PERIODS - 1);
  localparam logic [rts_pkg::BO_CNT_W-1:0] BO_LIMIT = rts_pkg::BO_CNT_W'(BROWNOUT_CYCLES);

  rts_pkg::rts_state_type state;
  rts_pkg::rts_state_type next_state;
  logic [rts_pkg::DELAY_CNT_W-1:0] delay_cnt;
  logic [rts_pkg::OSC_CNT_W-1:0] osc_cnt;
  logic [rts_pkg::BO_CNT_W-1:0] below_cnt;
  logic [1:0] power_status;
  logic [1:0] core_flags;
  logic [rts_pkg::IRQ_W-1:0] irq_status;
  logic [rts_pkg::IRQ_W-1:0] irq_mask;
  logic [rts_pkg::IRQ_W-1:0] events;
  logic brownout_trip;
  logic wdt_reset;
  logic wdt_wake;
  logic reset_source;
  logic crystal;
  logic delay_on;
  logic delay_done;
  logic settle_done;
  logic aw_full;
  logic w_full;
  logic [rts_pkg::ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic w_lane0;
  logic wr_en;
  rts_pkg::rts_sel_type wr_sel;
  rts_pkg::rts_sel_type rd_sel;
  logic [7:0] rd_byte;

  // brown-out persistence counter, idle while the fuse is clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      below_cnt <= '0;
    end else if (ce) begin
      if (!brownout_enable_fuse || !supply_below_threshold) begin
        below_cnt <= '0;
      end else if (below_cnt != BO_LIMIT) begin
        below_cnt <= below_cnt + 1'b1;
      end
    end
  end

  // reset sources and timer terms
  assign brownout_trip = brownout_enable_fuse && supply_below_threshold && (below_cnt == BO_LIMIT);
  assign wdt_reset = watchdog_timeout && !sleep_active;
  assign wdt_wake = watchdog_timeout && sleep_active;
  assign reset_source = power_on_pulse || brownout_trip || wdt_reset;
  assign crystal = is_crystal(osc_mode);
  assign delay_on = !startup_delay_enable_n;
  assign delay_done = (delay_cnt == DELAY_LAST);
  assign settle_done = osc_tick && (osc_cnt == SETTLE_LAST);

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      rts_pkg::RTS_HOLD: begin
        // wait out the pulse and the low supply, then pick the timers
        if (!reset_source && !supply_below_threshold) begin
          if (delay_on) begin
            next_state = rts_pkg::RTS_STARTUP;
          end else if (crystal) begin
            next_state = rts_pkg::RTS_SETTLE;
          end else begin
            next_state = rts_pkg::RTS_RUN;
          end
        end
      end
      rts_pkg::RTS_STARTUP: begin
        if (reset_source || supply_below_threshold) begin
          next_state = rts_pkg::RTS_HOLD;
        end else if (delay_done) begin
          next_state = crystal ? rts_pkg::RTS_SETTLE : rts_pkg::RTS_RUN;
        end
      end
      rts_pkg::RTS_SETTLE: begin
        if (reset_source) begin
          next_state = rts_pkg::RTS_HOLD;
        end else if (settle_done) begin
          next_state = rts_pkg::RTS_RUN;
        end
      end
      rts_pkg::RTS_RUN: begin
        if (reset_source) begin
          next_state = rts_pkg::RTS_HOLD;
        end else if (sleep_active && (wake_request || wdt_wake) && crystal) begin
          next_state = rts_pkg::RTS_WAKE;
        end
      end
      rts_pkg::RTS_WAKE: begin
        if (reset_source) begin
          next_state = rts_pkg::RTS_HOLD;
        end else if (settle_done) begin
          next_state = rts_pkg::RTS_RUN;
        end
      end
      default: next_state = rts_pkg::RTS_HOLD;
    endcase
  end

  // state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= rts_pkg::RTS_HOLD;
    end else if (ce) begin
      state <= next_state;
    end
  end

  // start-up delay counter, zero outside the delay so a dip restarts it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_cnt <= '0;
    end else if (ce) begin
      if (next_state != rts_pkg::RTS_STARTUP || state != rts_pkg::RTS_STARTUP) begin
        delay_cnt <= '0;
      end else begin
        delay_cnt <= delay_cnt + 1'b1;
      end
    end
  end

  // oscillator period counter for settle and wake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt <= '0;
    end else if (ce) begin
      if (next_state != state) begin
        osc_cnt <= '0;
      end else if ((state == rts_pkg::RTS_SETTLE || state == rts_pkg::RTS_WAKE) && osc_tick) begin
        osc_cnt <= osc_cnt + 1'b1;
      end
    end
  end

  // core reset and wake hold; the pin only gates the final release
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_reset <= 1'b1;
      wake_hold <= 1'b0;
    end else if (ce) begin
      core_reset <= (next_state != rts_pkg::RTS_RUN && next_state != rts_pkg::RTS_WAKE) ||
                    !external_reset_pin_n;
      wake_hold <= (next_state == rts_pkg::RTS_WAKE);
    end
  end

  // power status flags; hardware events win over a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_status <= rts_pkg::PS_RESET;
    end else if (ce) begin
      if (wr_en && wr_sel == rts_pkg::RTS_SEL_PS) begin
        power_status <= w_data[1:0];
      end
      if (power_on_pulse) begin
        power_status[rts_pkg::PS_POWER_ON_BIT] <= 1'b0;
      end else if (brownout_trip) begin
        power_status[rts_pkg::PS_BROWNOUT_BIT] <= 1'b0;
      end
    end
  end

  // core flags: expiry and sleep entry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_flags <= rts_pkg::CF_RESET;
    end else if (ce) begin
      if (wr_en && wr_sel == rts_pkg::RTS_SEL_CF) begin
        core_flags <= w_data[1:0];
      end
      if (power_on_pulse || brownout_trip) begin
        core_flags <= rts_pkg::CF_RESET;
      end else begin
        if (watchdog_timeout) begin
          core_flags[rts_pkg::CF_EXPIRY_BIT] <= 1'b0;
        end
        if (sleep_enter || wdt_wake) begin
          core_flags[rts_pkg::CF_SLEEP_BIT] <= 1'b0;
        end
      end
    end
  end

  // sticky events, write one to clear, set wins
  assign events[rts_pkg::EV_POWER_ON] = power_on_pulse;
  assign events[rts_pkg::EV_BROWNOUT] = brownout_trip;
  assign events[rts_pkg::EV_WDT_RESET] = wdt_reset;
  assign events[rts_pkg::EV_WDT_WAKE] = wdt_wake;
  assign events[rts_pkg::EV_RELEASE] = (next_state == rts_pkg::RTS_RUN) && (state != rts_pkg::RTS_RUN);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= rts_pkg::IRQ_RESET;
      irq_mask <= rts_pkg::IRQ_RESET;
    end else if (ce) begin
      if (wr_en && wr_sel == rts_pkg::RTS_SEL_IST) begin
        irq_status <= (irq_status & ~w_data[rts_pkg::IRQ_W-1:0]) | events;
      end else begin
        irq_status <= irq_status | events;
      end
      if (wr_en && wr_sel == rts_pkg::RTS_SEL_IMSK) begin
        irq_mask <= w_data[rts_pkg::IRQ_W-1:0];
      end
    end
  end

  assign irq = |(irq_status & irq_mask);

  // write address and data are caught in either order
  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready = !w_full && !s_axi_bvalid;
  assign wr_en = aw_full && w_full && !s_axi_bvalid && w_lane0;
  assign wr_sel = decode(aw_addr);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rts_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_lane0 <= s_axi_wstrb[0]; // only the low byte lane holds bits
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_sel == rts_pkg::RTS_SEL_NONE || wr_sel == rts_pkg::RTS_SEL_SEQ) ?
                       rts_pkg::RESP_SLVERR : rts_pkg::RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read mux, unimplemented bits read zero
  assign rd_sel = decode(s_axi_araddr);
  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_sel)
      rts_pkg::RTS_SEL_PS: rd_byte = {6'h00, power_status};
      rts_pkg::RTS_SEL_CF: rd_byte = {6'h00, core_flags};
      rts_pkg::RTS_SEL_SEQ: rd_byte = {2'h0, core_reset, state};
      rts_pkg::RTS_SEL_IST: rd_byte = {3'h0, irq_status};
      rts_pkg::RTS_SEL_IMSK: rd_byte = {3'h0, irq_mask};
      rts_pkg::RTS_SEL_NONE: rd_byte = 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rts_pkg::RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= (rd_sel == rts_pkg::RTS_SEL_NONE) ? rts_pkg::RESP_SLVERR : rts_pkg::RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // checks on the sequencing
  property p_fuse_off;
    @(posedge aclk) disable iff (!aresetn) ce && !brownout_enable_fuse |=> below_cnt == '0 && !brownout_trip;
  endproperty
  a_fuse_off: assert property (p_fuse_off) else $error("brown-out counted with fuse clear");

  property p_trip_resets;
    @(posedge aclk) disable iff (!aresetn) ce && brownout_trip |=> state == rts_pkg::RTS_HOLD && core_reset;
  endproperty
  a_trip_resets: assert property (p_trip_resets) else $error("brown-out did not reset");

  property p_hold_low_supply;
    @(posedge aclk) disable iff (!aresetn)
      ce && state == rts_pkg::RTS_HOLD && supply_below_threshold |=> state == rts_pkg::RTS_HOLD;
  endproperty
  a_hold_low_supply: assert property (p_hold_low_supply) else $error("left reset with low supply");

  property p_no_delay;
    @(posedge aclk) disable iff (!aresetn)
      ce && startup_delay_enable_n && state != rts_pkg::RTS_STARTUP |=> state != rts_pkg::RTS_STARTUP;
  endproperty
  a_no_delay: assert property (p_no_delay) else $error("delay started while disabled");

  property p_dip_restart;
    @(posedge aclk) disable iff (!aresetn) ce && state == rts_pkg::RTS_STARTUP && supply_below_threshold
      |=> state == rts_pkg::RTS_HOLD && delay_cnt == '0;
  endproperty
  a_dip_restart: assert property (p_dip_restart) else $error("delay not restarted on dip");

  property p_delay_then_settle;
    @(posedge aclk) disable iff (!aresetn) ce && state == rts_pkg::RTS_STARTUP && delay_done && crystal &&
      !reset_source && !supply_below_threshold |=> state == rts_pkg::RTS_SETTLE;
  endproperty
  a_delay_then_settle: assert property (p_delay_then_settle) else $error("settle did not follow delay");

  property p_settle_end;
    @(posedge aclk) disable iff (!aresetn) ce && state == rts_pkg::RTS_SETTLE && !reset_source && osc_tick &&
      osc_cnt == SETTLE_LAST |=> state == rts_pkg::RTS_RUN;
  endproperty
  a_settle_end: assert property (p_settle_end) else $error("settle count wrong");

  property p_bo_flag;
    @(posedge aclk) disable iff (!aresetn)
      ce && brownout_trip && !power_on_pulse |=> !power_status[rts_pkg::PS_BROWNOUT_BIT];
  endproperty
  a_bo_flag: assert property (p_bo_flag) else $error("brown-out flag not cleared");

  property p_por_flag;
    @(posedge aclk) disable iff (!aresetn) ce && power_on_pulse |=> !power_status[rts_pkg::PS_POWER_ON_BIT];
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag not cleared");

  property p_wdt_flag;
    @(posedge aclk) disable iff (!aresetn) ce && watchdog_timeout && !power_on_pulse && !brownout_trip
      |=> !core_flags[rts_pkg::CF_EXPIRY_BIT];
  endproperty
  a_wdt_flag: assert property (p_wdt_flag) else $error("expiry flag not cleared");

  property p_release;
    @(posedge aclk) disable iff (!aresetn) ce && next_state == rts_pkg::RTS_RUN && external_reset_pin_n
      |=> !core_reset ##0 $past(state) != rts_pkg::RTS_HOLD || !$past(delay_on);
  endproperty
  a_release: assert property (p_release) else $error("core reset not released");

  property p_hold_busy;
    @(posedge aclk) disable iff (!aresetn) ce && (next_state == rts_pkg::RTS_STARTUP ||
      next_state == rts_pkg::RTS_SETTLE || next_state == rts_pkg::RTS_HOLD) |=> core_reset;
  endproperty
  a_hold_busy: assert property (p_hold_busy) else $error("core released while busy");

endmodule

// ---- hw/rts_pkg.sv ----
// constants, register map and types of the reset timeout sequencer
package rts_pkg;

  // clock and timing
  localparam longint CLK_HZ = 64'd10_000_000;
  localparam longint STARTUP_DELAY_MS = 64'd72;
  // least time, so the count rounds up
  localparam int STARTUP_DELAY_CYCLES = int'((STARTUP_DELAY_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam int SETTLE_OSC_PERIODS = 1024;
  localparam int BROWNOUT_MIN_CYCLES = 16;
  localparam int DELAY_CNT_W = 20;
  localparam int OSC_CNT_W = 11;
  localparam int BO_CNT_W = 16;

  // register indices; byte address is four times the index
  localparam int ADDR_W = 12;
  localparam logic [9:0] IDX_POWER_STATUS = 10'h08e;
  localparam logic [9:0] IDX_CORE_FLAGS = 10'h090;
  localparam logic [9:0] IDX_SEQ_STATE = 10'h091;
  localparam logic [9:0] IDX_IRQ_STATUS = 10'h092;
  localparam logic [9:0] IDX_IRQ_MASK = 10'h093;

  // power_status fields
  localparam int PS_BROWNOUT_BIT = 0;
  localparam int PS_POWER_ON_BIT = 1;
  localparam logic [1:0] PS_RESET = 2'h0;
  // core_flags fields
  localparam int CF_EXPIRY_BIT = 0;
  localparam int CF_SLEEP_BIT = 1;
  localparam logic [1:0] CF_RESET = 2'h3;
  // interrupt status fields
  localparam int IRQ_W = 5;
  localparam int EV_POWER_ON = 0;
  localparam int EV_BROWNOUT = 1;
  localparam int EV_WDT_RESET = 2;
  localparam int EV_WDT_WAKE = 3;
  localparam int EV_RELEASE = 4;
  localparam logic [4:0] IRQ_RESET = 5'h00;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register select codes
  typedef enum logic [2:0] {
    RTS_SEL_NONE = 3'h0, RTS_SEL_PS = 3'h1, RTS_SEL_CF = 3'h2,
    RTS_SEL_SEQ = 3'h3, RTS_SEL_IST = 3'h4, RTS_SEL_IMSK = 3'h5
  } rts_sel_type;

  // oscillator configurations
  typedef enum logic [2:0] {
    RTS_CRYSTAL_MODE = 3'h0, RTS_HIGH_SPEED_CRYSTAL_MODE = 3'h1, RTS_LOW_POWER_CRYSTAL_MODE = 3'h2,
    RTS_RESISTOR_CAP_OSC_MODE = 3'h3, RTS_EXTERNAL_CLOCK_MODE = 3'h4, RTS_INTERNAL_OSCILLATOR_MODE = 3'h5
  } rts_osc_mode_type;

  // sequencer states, one-hot
  typedef enum logic [4:0] {
    RTS_HOLD = 5'h01, RTS_STARTUP = 5'h02, RTS_SETTLE = 5'h04, RTS_RUN = 5'h08, RTS_WAKE = 5'h10
  } rts_state_type;

endpackage

// ---- bench/rts_supply_model.sv ----
// model of the supply comparator and the external reset pin
module rts_supply_model (
  input wire logic aclk,
  output logic power_on_pulse,
  output logic supply_below_threshold,
  output logic external_reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // supply good, pin released at time zero
  initial begin
    power_on_pulse = 1'b0;
    supply_below_threshold = 1'b0;
    external_reset_pin_n = 1'b1;
  end

  // power-on pulse; the supply is still low while it lasts
  task automatic power_up(input int n);
    @(posedge aclk);
    power_on_pulse <= 1'b1;
    supply_below_threshold <= 1'b1;
    repeat (n) @(posedge aclk);
    power_on_pulse <= 1'b0;
    supply_below_threshold <= 1'b0;
  endtask

  // supply dip of n cycles, any slew
  task automatic dip(input int n);
    @(posedge aclk);
    supply_below_threshold <= 1'b1;
    repeat (n) @(posedge aclk);
    supply_below_threshold <= 1'b0;
  endtask

  // pin level, changed just after an edge
  task automatic pin(input logic lvl);
    @(posedge aclk);
    external_reset_pin_n <= lvl;
  endtask
endmodule

// ---- bench/reset_timeout_sequencer_test.sv ----
// self-checking testbench of the reset timeout sequencer
module reset_timeout_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int S = 20;
  localparam int B = 3;
  localparam logic [11:0] A_PS = {rts_pkg::IDX_POWER_STATUS, 2'b00};
  localparam logic [11:0] A_CF = {rts_pkg::IDX_CORE_FLAGS, 2'b00};
  localparam logic [11:0] A_SEQ = {rts_pkg::IDX_SEQ_STATE, 2'b00};
  localparam logic [11:0] A_IST = {rts_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [11:0] A_IMSK = {rts_pkg::IDX_IRQ_MASK, 2'b00};
  logic aclk, aresetn, fuse, dly_n, wdt, por, below, pin_n, core_reset, irq, ce, slp_in, slp, wake_rq, wake_hold;
  logic tick = 1'b0;
  logic [3:0] strb;
  logic [2:0] mode;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int miscompares, n_tests, cyc, n;

  rts_supply_model model (.aclk(aclk), .power_on_pulse(por), .supply_below_threshold(below),
    .external_reset_pin_n(pin_n));
  rts_sequencer #(.STARTUP_CYCLES(S), .BROWNOUT_CYCLES(B)) dut (.aclk(aclk), .aresetn(aresetn),
    .ce(ce), .power_on_pulse(por), .supply_below_threshold(below), .external_reset_pin_n(pin_n),
    .brownout_enable_fuse(fuse), .startup_delay_enable_n(dly_n), .osc_mode(mode), .osc_tick(tick),
    .watchdog_timeout(wdt), .sleep_enter(slp_in), .sleep_active(slp), .wake_request(wake_rq),
    .core_reset(core_reset), .wake_hold(wake_hold), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  // clock, oscillator tick every second cycle, hang guard
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    tick <= ~tick;
    cyc++;
    if (cyc == 60000) begin
      miscompares++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // axi4-lite write; each channel released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  // axi4-lite read, compared with data and response
  task automatic rdc(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, ed);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  // cycles until the core is let go
  task automatic wait_rel(output int k);
    k = 0;
    do begin
      @(posedge aclk);
      k++;
    end while (core_reset !== 1'b0 && k < 5000);
  endtask

  task automatic in_range(input int k, input int lo, input int hi);
    check({31'h0, k >= lo && k <= hi}, 32'h1);
  endtask

  // every mode with the delay on and off
  task automatic t_timeouts();
    int lo;
    logic [1:0] r;
    wr(A_PS, 32'h3, r);
    for (int m = 0; m < 6; m++) begin
      for (int d = 0; d < 2; d++) begin
        mode <= 3'(m);
        dly_n <= d[0];
        model.power_up(4);
        wait_rel(n);
        lo = (d == 1 ? 0 : S) + (m < 3 ? 2040 : 0);
        in_range(n, lo, lo + 20);
      end
    end
    rdc(A_PS, 32'h1, rts_pkg::RESP_OKAY);
  endtask

  // fuse off, short dip, real brown-out without delay
  task automatic t_brownout();
    logic [1:0] r;
    mode <= 3'h3;
    dly_n <= 1'b1;
    wr(A_PS, 32'h3, r);
    fuse <= 1'b0;
    model.dip(10);
    check({31'h0, core_reset}, 32'h0);
    fuse <= 1'b1;
    model.dip(1);
    check({31'h0, core_reset}, 32'h0);
    model.dip(8);
    check({31'h0, core_reset}, 32'h1);
    wait_rel(n);
    in_range(n, 1, 6);
    rdc(A_PS, 32'h2, rts_pkg::RESP_OKAY);
  endtask

  // dip during the start-up delay restarts it
  task automatic t_restart();
    dly_n <= 1'b0;
    model.dip(8);
    repeat (S / 2) @(posedge aclk);
    model.dip(1);
    wait_rel(n);
    in_range(n, S, S + 6);
  endtask

  // pin held past the timeouts releases at once
  task automatic t_pin();
    mode <= 3'h0;
    model.pin(1'b0);
    model.power_up(4);
    repeat (S + 2100) @(posedge aclk);
    check({31'h0, core_reset}, 32'h1);
    model.pin(1'b1);
    wait_rel(n);
    in_range(n, 1, 3);
  endtask

  // watchdog reset flag and interrupt mask, set and clear
  task automatic t_watchdog();
    logic [1:0] r;
    wr(A_IST, 32'h1f, r);
    wr(A_IMSK, 32'h4, r);
    check({31'h0, irq}, 32'h0);
    @(posedge aclk);
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
    rdc(A_CF, 32'h2, rts_pkg::RESP_OKAY);
    check({31'h0, irq}, 32'h1);
    wr(A_IMSK, 32'h0, r);
    check({31'h0, irq}, 32'h0);
    wr(A_IMSK, 32'h4, r);
    check({31'h0, irq}, 32'h1);
    wr(A_IST, 32'h4, r);
    check({31'h0, irq}, 32'h0);
    wait_rel(n);
  endtask

  // read-only and unmapped places
  task automatic t_bus();
    logic [1:0] r;
    wr(A_SEQ, 32'h1f, r);
    check({30'h0, r}, {30'h0, rts_pkg::RESP_SLVERR});
    wr(12'h100, 32'h1, r);
    check({30'h0, r}, {30'h0, rts_pkg::RESP_SLVERR});
    rdc(12'h100, 32'h0, rts_pkg::RESP_SLVERR);
    rdc(A_SEQ, 32'h08, rts_pkg::RESP_OKAY);
    strb <= 4'he;
    wr(A_IMSK, 32'h1f, r);
    strb <= 4'hf;
    check({30'h0, r}, {30'h0, rts_pkg::RESP_OKAY});
    rdc(A_IMSK, 32'h4, rts_pkg::RESP_OKAY);
  endtask

  // sleep entry, watchdog wake with settle, no wake off crystal, frozen delay
  task automatic t_sleep();
    logic [1:0] r;
    wr(A_CF, 32'h3, r);
    slp_in <= 1'b1;
    @(posedge aclk);
    slp_in <= 1'b0;
    rdc(A_CF, 32'h1, rts_pkg::RESP_OKAY);
    slp <= 1'b1;
    wdt <= 1'b1;
    @(posedge aclk);
    wdt <= 1'b0;
    @(posedge aclk);
    check({30'h0, core_reset, wake_hold}, 32'h1);
    rdc(A_CF, 32'h0, rts_pkg::RESP_OKAY);
    repeat (2030) @(posedge aclk);
    check({30'h0, core_reset, wake_hold}, 32'h1);
    repeat (30) @(posedge aclk);
    check({30'h0, core_reset, wake_hold}, 32'h0);
    mode <= 3'h3;
    wake_rq <= 1'b1;
    @(posedge aclk);
    wake_rq <= 1'b0;
    slp <= 1'b0;
    @(posedge aclk);
    check({30'h0, core_reset, wake_hold}, 32'h0);
    model.power_up(4);
    repeat (5) @(posedge aclk);
    ce <= 1'b0;
    repeat (10) @(posedge aclk);
    ce <= 1'b1;
    wait_rel(n);
    in_range(n, S - 3, S - 3);
  endtask

  // inputs at time zero, reset, scenarios
  initial begin
    {aresetn, wdt, slp_in, slp, wake_rq, awvalid, wvalid, bready, arvalid, rready} = '0;
    {fuse, dly_n, mode, awaddr, araddr, wdata} = '0;
    fuse = 1'b1;
    ce = 1'b1;
    strb = 4'hf;
    miscompares = 0;
    n_tests = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(A_PS, 32'h0, rts_pkg::RESP_OKAY);
    rdc(A_CF, 32'h3, rts_pkg::RESP_OKAY);
    rdc(A_IMSK, 32'h0, rts_pkg::RESP_OKAY);
    t_timeouts();
    t_brownout();
    t_restart();
    t_pin();
    t_watchdog();
    t_bus();
    t_sleep();
    end_sim();
  end
endmodule
